// >>> rtl/sleep_ctrl_defs.svh
// register offsets, field positions, reset values and timing for the sleep controller
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH

// ----------------------------------------
// register offsets and reset value
// ----------------------------------------
`define SLEEP_MODE_CONTROL_ADDR 8'h33
`define MCU_CONTROL_ADDR 8'h35
`define MODULE_CLOCK_GATE_0_ADDR 8'h64
`define MODULE_CLOCK_GATE_1_ADDR 8'h65
`define REG_RESET_VALUE 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define SLEEP_ARM_BIT 0
`define SLEEP_MODE_LSB 1
`define SLEEP_MODE_MSB 3
`define VECTOR_UNLOCK_BIT 0
`define VECTOR_RELOCATE_BIT 1
`define PULLUP_DISABLE_BIT 4
`define FLASH_SLEEP_OFF_BIT 6
`define FAST_WAKE_BIT 7

// ----------------------------------------
// writable bits of the clock-gate registers
// ----------------------------------------
`define GATE0_MASK 8'hef
`define GATE1_MASK 8'h26

// ----------------------------------------
// module clocks allowed to run per sleep mode
// ----------------------------------------
// gate 0: adc, timer 2, two-wire
`define ADC_MODE_RUN0 8'hc1
// gate 1: pin change, watchdog
`define ADC_MODE_RUN1 8'h22
// async timer 2 only
`define PDOWN_RUN0 8'h40
`define PDOWN_RUN1 8'h22
`define OFF_S0_RUN1 8'h20
`define ALL_STOPPED 8'h00
`define ALL_RUNNING 8'hff

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 40
`define RESUME_CYC 4
`define VEC_WINDOW_CYC 6
`define WAKE_FILT_LONG_US 260
`define WAKE_FILT_SHORT_US 32

`endif

// >>> rtl/sleep_ctrl_pkg.sv
// types shared by the sleep-mode power controller
package sleep_ctrl_pkg;

  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_sleep = 2'b01,
    st_wake = 2'b10
  } ctrl_state_t;

  typedef enum logic [2:0] {
    mode_idle = 3'b000,
    mode_adc = 3'b001,
    mode_pdown = 3'b010,
    mode_off_s1 = 3'b011,
    mode_off_lock = 3'b100,
    mode_off_s0 = 3'b110
  } power_mode_t;

  typedef struct packed {
    ctrl_state_t state;
    power_mode_t mode;
    logic [2:0] wait_cnt;
    logic sleep_arm;
    logic [2:0] sleep_mode_select;
    logic fast_wake_filter_select;
    logic flash_sleep_power_off;
    logic global_pullup_disable;
    logic vector_relocate_select;
    logic [2:0] unlock_cnt;
    logic [7:0] gate0;
    logic [7:0] gate1;
    logic [7:0] rdata;
    logic [1:0] ext_meta;
    logic [1:0] ext_sync;
    logic boot_pend;
    logic boot;
    logic resume;
    logic take_isr;
    logic adc_start;
  } ctrl_regs_t;

endpackage

// >>> rtl/wake_filter.sv
// glitch filter for power-off wake requests
`timescale 1ns/1ps
module wake_filter #(
  parameter int LONG_CYC = 10400,
  parameter int SHORT_CYC = 1280
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic arm_in,
  input wire logic level_in,
  input wire logic fast_in,
  output logic pass_out
);

  localparam int CW = $clog2(LONG_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic pass;
  } filt_state_t;

  filt_state_t s;
  filt_state_t next_s;
  logic [CW-1:0] last;

  // ----------------------------------------
  // count consecutive active cycles
  // ----------------------------------------
  always_comb begin
    next_s = s;
    last = fast_in ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
    if (clk_en_in) begin
      // any drop restarts the width, so short spikes never wake
      if (!arm_in || !level_in) begin
        next_s.count = '0;
        next_s.pass = 1'b0;
      end else if (s.count >= last) begin
        next_s.pass = 1'b1;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pass_out = s.pass;

endmodule

// >>> rtl/sleep_mode_power_controller.sv
// sleep-mode power controller: registers, sleep sequencing, wake and clock gating
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "sleep_ctrl_defs.svh"

// Summary of operation
// R1: sleep is entered on the sleep instruction only while the arm bit is set
// R2: an enabled wake source during sleep restarts the core four cycles later
// R3: if the waking interrupt is still pending at resume, vector to its handler
// R4: a system reset during sleep wakes the device at the reset vector
// R5: power-off wake by external irq 0 or 1 resumes after the sleep point
// R6: mode field codes idle, adc, power-down, off s1, lock, off s0; rest reserved
// R7: idle stops only core clock and fetch; any interrupt wakes
// R8: adc mode keeps adc, external irqs, two-wire match, watchdog, timer 2
// R9: adc mode entry starts a conversion; its completion interrupt wakes
// R10: power-down gates module clocks, keeps master clock; limited wake sources
// R11: power-off s0 keeps only the slow rc; external irqs or enabled watchdog wake
// R12: power-off s1 stops all clocks; only external irqs wake
// R13: software enables and configures the wake source before power-off
// R14: flash power bit removes flash supply while the core sleeps
// R15: fast-wake bit picks 260us or 32us wake filter, power-off only
// R16: first gate register bits stop adc, serial, spi, timers and two-wire clocks
// R17: second gate register bits stop pin-change, flash interface, watchdog clocks
// R18: relocate bit accepted only within six cycles after the unlock bit
// R19: pull-up disable bit globally disables i/o pull-ups
// R20: system reset returns all registers to initial values, starts at reset vector
// R21: software arms just before sleep and disarms right after waking
// R22: sleep instruction with arm clear or reserved mode is a no-operation
module sleep_mode_power_controller #(
  parameter int LONG_FILT_CYC = `WAKE_FILT_LONG_US * `CLK_MHZ,
  parameter int SHORT_FILT_CYC = `WAKE_FILT_SHORT_US * `CLK_MHZ
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sleep_instr_in,
  input wire logic [1:0] ext_irq_in,
  input wire logic irq_any_in,
  input wire logic irq_pending_in,
  input wire logic adc_done_in,
  input wire logic two_wire_match_in,
  input wire logic timer2_irq_in,
  input wire logic watchdog_irq_in,
  input wire logic watchdog_irq_en_in,
  output logic core_clk_en_out,
  output logic resume_out,
  output logic take_isr_out,
  output logic boot_from_reset_out,
  output logic adc_start_out,
  output logic [7:0] module_clk_en0_out,
  output logic [7:0] module_clk_en1_out,
  output logic main_osc_en_out,
  output logic slow_rc_en_out,
  output logic flash_power_off_out,
  output logic pullup_disable_out,
  output logic vector_relocate_out,
  output logic sleeping_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic mode_valid(input logic [2:0] code);
    case (code)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6: mode_valid = 1'b1;
      default: mode_valid = 1'b0;
    endcase
  endfunction

  function automatic logic is_off(input sleep_ctrl_pkg::power_mode_t m);
    case (m)
      sleep_ctrl_pkg::mode_off_s0,
      sleep_ctrl_pkg::mode_off_s1,
      sleep_ctrl_pkg::mode_off_lock: is_off = 1'b1;
      default: is_off = 1'b0;
    endcase
  endfunction

  function automatic logic wake_of(
    input sleep_ctrl_pkg::power_mode_t m,
    input logic ext,
    input logic irq,
    input logic adc,
    input logic two_wire_interface,
    input logic t2,
    input logic wdt,
    input logic wdt_en
  );
    case (m)
      // R7: idle wake
      sleep_ctrl_pkg::mode_idle: wake_of = ext | irq;
      // R9: conversion done wakes
      sleep_ctrl_pkg::mode_adc: wake_of = ext | adc | two_wire_interface | wdt | t2;
      // R10: power-down wake
      sleep_ctrl_pkg::mode_pdown: wake_of = ext | two_wire_interface | wdt | t2;
      // R11: s0 watchdog if enabled
      sleep_ctrl_pkg::mode_off_s0: wake_of = ext | (wdt & wdt_en);
      // R12: external irqs only
      default: wake_of = ext;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  sleep_ctrl_pkg::ctrl_regs_t s;
  sleep_ctrl_pkg::ctrl_regs_t next_s;
  logic ext_wake;
  logic raw_wake;
  logic off_now;
  logic filt_pass;
  logic wake;

  assign ext_wake = |s.ext_sync;
  assign off_now = is_off(s.mode);
  assign raw_wake = wake_of(s.mode, ext_wake, irq_any_in, adc_done_in,
    two_wire_match_in, timer2_irq_in, watchdog_irq_in, watchdog_irq_en_in);

  // R15: filter only in power-off
  wake_filter #(
    .LONG_CYC(LONG_FILT_CYC),
    .SHORT_CYC(SHORT_FILT_CYC)
  ) u_filter (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .arm_in((s.state == sleep_ctrl_pkg::st_sleep) && off_now),
    .level_in(raw_wake),
    .fast_in(s.fast_wake_filter_select),
    .pass_out(filt_pass)
  );

  assign wake = off_now ? filt_pass : raw_wake;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    if (clk_en_in) begin
      next_s.resume = 1'b0;
      next_s.take_isr = 1'b0;
      next_s.adc_start = 1'b0;
      next_s.rdata = 8'h00;
      // pins pass two flops before use
      next_s.ext_meta = ext_irq_in;
      next_s.ext_sync = s.ext_meta;
      // R4: reset vector after any reset
      next_s.boot_pend = 1'b0;
      next_s.boot = s.boot_pend;
      if (s.unlock_cnt != 3'h0) begin
        next_s.unlock_cnt = s.unlock_cnt - 3'h1;
      end

      if (reg_wr_in) begin
        case (reg_addr_in)
          `SLEEP_MODE_CONTROL_ADDR: begin
            next_s.sleep_arm = reg_wdata_in[`SLEEP_ARM_BIT];
            next_s.sleep_mode_select = reg_wdata_in[`SLEEP_MODE_MSB:`SLEEP_MODE_LSB];
          end
          `MCU_CONTROL_ADDR: begin
            next_s.fast_wake_filter_select = reg_wdata_in[`FAST_WAKE_BIT];
            next_s.flash_sleep_power_off = reg_wdata_in[`FLASH_SLEEP_OFF_BIT];
            next_s.global_pullup_disable = reg_wdata_in[`PULLUP_DISABLE_BIT];
            // R18: relocate only in window
            if (s.unlock_cnt != 3'h0) begin
              next_s.vector_relocate_select = reg_wdata_in[`VECTOR_RELOCATE_BIT];
              next_s.unlock_cnt = 3'h0;
            end else if (reg_wdata_in[`VECTOR_UNLOCK_BIT]) begin
              next_s.unlock_cnt = 3'(`VEC_WINDOW_CYC);
            end
          end
          // R16: first gate register
          `MODULE_CLOCK_GATE_0_ADDR: next_s.gate0 = reg_wdata_in & `GATE0_MASK;
          // R17: second gate register
          `MODULE_CLOCK_GATE_1_ADDR: next_s.gate1 = reg_wdata_in & `GATE1_MASK;
          default: next_s.gate0 = s.gate0;
        endcase
      end

      if (reg_rd_in) begin
        case (reg_addr_in)
          `SLEEP_MODE_CONTROL_ADDR:
            next_s.rdata = {4'h0, s.sleep_mode_select, s.sleep_arm};
          `MCU_CONTROL_ADDR:
            next_s.rdata = {s.fast_wake_filter_select, s.flash_sleep_power_off,
              1'b0, s.global_pullup_disable, 2'b00,
              s.vector_relocate_select, s.unlock_cnt != 3'h0};
          `MODULE_CLOCK_GATE_0_ADDR: next_s.rdata = s.gate0;
          `MODULE_CLOCK_GATE_1_ADDR: next_s.rdata = s.gate1;
          // unmapped reads return zero
          default: next_s.rdata = 8'h00;
        endcase
      end

      case (s.state)
        sleep_ctrl_pkg::st_run: begin
          // R1: arm bit required
          // R22: otherwise a no-operation
          if (sleep_instr_in && s.sleep_arm && mode_valid(s.sleep_mode_select)) begin
            // R6: mode decode
            next_s.mode = sleep_ctrl_pkg::power_mode_t'(s.sleep_mode_select);
            next_s.state = sleep_ctrl_pkg::st_sleep;
            // R9: auto conversion start
            next_s.adc_start = (s.sleep_mode_select == sleep_ctrl_pkg::mode_adc);
          end
        end
        sleep_ctrl_pkg::st_sleep: begin
          // R2: start resume countdown
          if (wake) begin
            next_s.state = sleep_ctrl_pkg::st_wake;
            next_s.wait_cnt = 3'(`RESUME_CYC - 2);
          end
        end
        sleep_ctrl_pkg::st_wake: begin
          if (s.wait_cnt == 3'h0) begin
            // R5: resume in place, no reset
            next_s.state = sleep_ctrl_pkg::st_run;
            next_s.resume = 1'b1;
            // R3: pending irq is taken at once
            next_s.take_isr = irq_pending_in;
          end else begin
            next_s.wait_cnt = s.wait_cnt - 3'h1;
          end
        end
        default: next_s.state = sleep_ctrl_pkg::st_run;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // R20: everything to initial values
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.boot_pend <= 1'b1;
      s.gate0 <= `REG_RESET_VALUE;
      s.gate1 <= `REG_RESET_VALUE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // clock and power controls
  // ----------------------------------------
  logic asleep;
  logic [7:0] run0;
  logic [7:0] run1;

  assign asleep = (s.state != sleep_ctrl_pkg::st_run);

  always_comb begin
    run0 = `ALL_RUNNING;
    run1 = `ALL_RUNNING;
    if (asleep) begin
      case (s.mode)
        // R7: peripherals keep running
        sleep_ctrl_pkg::mode_idle: run0 = `ALL_RUNNING;
        // R8: adc mode survivors
        sleep_ctrl_pkg::mode_adc: begin
          run0 = `ADC_MODE_RUN0;
          run1 = `ADC_MODE_RUN1;
        end
        // R10: async timer and wake logic only
        sleep_ctrl_pkg::mode_pdown: begin
          run0 = `PDOWN_RUN0;
          run1 = `PDOWN_RUN1;
        end
        // R11: watchdog on slow rc
        sleep_ctrl_pkg::mode_off_s0: begin
          run0 = `ALL_STOPPED;
          run1 = `OFF_S0_RUN1;
        end
        default: begin
          run0 = `ALL_STOPPED;
          run1 = `ALL_STOPPED;
        end
      endcase
    end
  end

  // R16: set gate bit stops clock
  assign module_clk_en0_out = run0 & ~s.gate0;
  // R17: set gate bit stops clock
  assign module_clk_en1_out = run1 & ~s.gate1;
  // R7: core clock and fetch stop
  assign core_clk_en_out = !asleep;
  // R11: master source off in power-off
  assign main_osc_en_out = !(asleep && off_now);
  // R12: slow rc off in s1 and lock
  assign slow_rc_en_out = !(asleep && off_now && (s.mode != sleep_ctrl_pkg::mode_off_s0));
  // R14: flash supply in sleep
  assign flash_power_off_out = asleep && s.flash_sleep_power_off;
  // R19: global pull-up disable
  assign pullup_disable_out = s.global_pullup_disable;
  assign vector_relocate_out = s.vector_relocate_select;
  assign sleeping_out = asleep;
  assign reg_rdata_out = s.rdata;
  assign resume_out = s.resume;
  assign take_isr_out = s.take_isr;
  assign boot_from_reset_out = s.boot;
  assign adc_start_out = s.adc_start;

endmodule

// >>> sim/sleep_ctrl_checker.sv
// concurrent checks on the sleep controller ports
`timescale 1ns/1ps
module sleep_ctrl_checker (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic sleep_instr_in,
  input wire logic core_clk_en_out,
  input wire logic resume_out,
  input wire logic take_isr_out,
  input wire logic boot_from_reset_out,
  input wire logic adc_start_out,
  input wire logic main_osc_en_out,
  input wire logic slow_rc_en_out,
  input wire logic flash_power_off_out,
  input wire logic sleeping_out
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_sleep_no_core:
    assert property (sleeping_out |-> !core_clk_en_out && !resume_out)
    else $error("core runs while asleep");
  a_entry_cause:
    assert property ($rose(sleeping_out) |-> $past(sleep_instr_in))
    else $error("sleep entered without instruction");
  a_resume_wait:
    assert property (resume_out |-> $past(sleeping_out, 4) && !$past(core_clk_en_out))
    else $error("resume without four gated cycles");
  a_resume_pulse:
    assert property (resume_out |=> !resume_out && core_clk_en_out)
    else $error("resume pulse malformed");
  a_isr_pair:
    assert property (take_isr_out |-> resume_out) else $error("handler jump without resume");
  a_boot_pulse:
    assert property (boot_from_reset_out |-> core_clk_en_out ##1 !boot_from_reset_out)
    else $error("reset vector pulse malformed");
  a_flash_sleep:
    assert property (flash_power_off_out |-> sleeping_out) else $error("flash off while awake");
  a_adc_start:
    assert property (adc_start_out |-> sleeping_out && $past(sleep_instr_in) ##1 !adc_start_out)
    else $error("conversion start outside entry");
  a_osc_run:
    assert property (core_clk_en_out |-> main_osc_en_out && slow_rc_en_out)
    else $error("oscillator off while core runs");
endmodule

bind sleep_mode_power_controller sleep_ctrl_checker chk_i (
  .clock_in, .rst_n_in, .sleep_instr_in, .core_clk_en_out, .resume_out, .take_isr_out,
  .boot_from_reset_out, .adc_start_out, .main_osc_en_out, .slow_rc_en_out,
  .flash_power_off_out, .sleeping_out
);

// >>> sim/core_model.sv
// behavioural processor core issuing sleep instructions
`timescale 1ns/1ps
module core_model (
  input wire logic clock_in,
  input wire logic take_isr_in,
  output logic sleep_instr_out,
  output logic irq_pending_out
);
  initial begin
    sleep_instr_out = 1'b0;
    irq_pending_out = 1'b0;
  end
  task automatic exec_sleep(input logic pend);
    @(posedge clock_in);
    sleep_instr_out <= 1'b1;
    irq_pending_out <= pend;
    @(posedge clock_in);
    sleep_instr_out <= 1'b0;
    #1;
  endtask
  always @(posedge clock_in) begin
    if (take_isr_in) begin
      irq_pending_out <= 1'b0;
    end
  end
endmodule

// >>> sim/tb.sv
// testbench for the sleep-mode power controller
`timescale 1ns/1ps
module tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, irq_any_in = 1'b0, adc_done_in = 1'b0;
  logic [1:0] ext_irq_in = 2'h0;
  logic clk_en_in = 1'b1, two_wire_match_in = 1'b0, timer2_irq_in = 1'b0;
  logic watchdog_irq_in = 1'b0, watchdog_irq_en_in = 1'b0;
  logic [7:0] reg_rdata_out, module_clk_en0_out, module_clk_en1_out;
  logic core_clk_en_out, resume_out, take_isr_out, boot_from_reset_out, adc_start_out;
  logic main_osc_en_out, slow_rc_en_out, flash_power_off_out, pullup_disable_out;
  logic vector_relocate_out, sleeping_out, sleep_instr_in, irq_pending_in;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  // short filters keep power-off wakes quick
  localparam int long_filt = 20;
  localparam int short_filt = 5;
  localparam logic [2:0] mode_codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  localparam logic [7:0] run0 [6] = '{8'hff, 8'hc1, 8'h40, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] run1 [6] = '{8'hff, 8'h22, 8'h22, 8'h00, 8'h00, 8'h20};
  localparam logic [7:0] oscs [6] = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'h01};
  localparam logic [7:0] noops [4] = '{8'h00, 8'h04, 8'h0b, 8'h0f};

  always #12.5 clock_in = ~clock_in;

  sleep_mode_power_controller #(.LONG_FILT_CYC(long_filt), .SHORT_FILT_CYC(short_filt)) dut (
    .clock_in, .rst_n_in, .clk_en_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .sleep_instr_in, .ext_irq_in, .irq_any_in, .irq_pending_in,
    .adc_done_in, .two_wire_match_in, .timer2_irq_in, .watchdog_irq_in,
    .watchdog_irq_en_in, .core_clk_en_out, .resume_out, .take_isr_out,
    .boot_from_reset_out, .adc_start_out, .module_clk_en0_out, .module_clk_en1_out,
    .main_osc_en_out, .slow_rc_en_out, .flash_power_off_out, .pullup_disable_out,
    .vector_relocate_out, .sleeping_out
  );
  core_model core (.clock_in, .take_isr_in(take_isr_out), .sleep_instr_out(sleep_instr_in),
    .irq_pending_out(irq_pending_in));

  // ----
  // shared tasks
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  task automatic wait_resume();
    n = 0;
    while (resume_out !== 1'b1 && n < 100) begin
      @(posedge clock_in);
      #1 n++;
    end
    if (n == 100) begin
      fail_count++;
      wrap_up();
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rc(8'h33, 8'h00);
    rc(8'h35, 8'h00);
    rc(8'h64, 8'h00);
    rc(8'h65, 8'h00);
    wr(8'h33, 8'hff);
    rc(8'h33, 8'h0f);
    wr(8'h64, 8'hff);
    rc(8'h64, 8'hef);
    chk(module_clk_en0_out, 8'h10);
    wr(8'h65, 8'hff);
    rc(8'h65, 8'h26);
    chk(module_clk_en1_out, 8'hd9);
    wr(8'h34, 8'hff);
    rc(8'h34, 8'h00);
    wr(8'h35, 8'h10);
    chkb(pullup_disable_out, 1'b1);
    rc(8'h35, 8'h10);
    wr(8'h33, 8'h00);
    wr(8'h64, 8'h00);
    wr(8'h65, 8'h00);
    wr(8'h35, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_vector();
    wr(8'h35, 8'h01);
    rc(8'h35, 8'h01);
    wr(8'h35, 8'h00);
    wr(8'h35, 8'h01);
    // one cycle past the window
    repeat (5) @(posedge clock_in);
    wr(8'h35, 8'h02);
    chkb(vector_relocate_out, 1'b0);
    wr(8'h35, 8'h01);
    repeat (4) @(posedge clock_in);
    wr(8'h35, 8'h02);
    chkb(vector_relocate_out, 1'b1);
    wr(8'h35, 8'h01);
    wr(8'h35, 8'h00);
    $display("test vector done");
  endtask
  task automatic t_idle();
    wr(8'h33, 8'h01);
    core.exec_sleep(1'b1);
    chkb(sleeping_out, 1'b1);
    chkb(core_clk_en_out, 1'b0);
    chk(module_clk_en0_out, 8'hff);
    @(posedge clock_in);
    irq_any_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1 chkb(resume_out, 1'b0);
    @(posedge clock_in);
    #1 chkb(resume_out, 1'b1);
    chkb(take_isr_out, 1'b1);
    irq_any_in <= 1'b0;
    wr(8'h33, 8'h00);
    $display("test idle done");
  endtask
  task automatic t_noop();
    for (int i = 0; i < 4; i++) begin
      wr(8'h33, noops[i]);
      core.exec_sleep(1'b0);
      chkb(sleeping_out, 1'b0);
      chkb(core_clk_en_out, 1'b1);
    end
    $display("test noop done");
  endtask
  task automatic t_modes();
    for (int i = 0; i < 6; i++) begin
      wr(8'h35, (i == 3) ? 8'h40 : 8'hc0);
      wr(8'h33, {4'h0, mode_codes[i], 1'h1});
      core.exec_sleep(1'b0);
      chk(module_clk_en0_out, run0[i]);
      chk(module_clk_en1_out, run1[i]);
      chk({6'h00, main_osc_en_out, slow_rc_en_out}, oscs[i]);
      chkb(adc_start_out, i == 1);
      chkb(flash_power_off_out, 1'b1);
      if (i > 0) begin
        irq_any_in <= 1'b1;
        repeat (30) @(posedge clock_in);
        #1 chkb(sleeping_out, 1'b1);
        irq_any_in <= 1'b0;
      end
      if (i == 1) begin
        adc_done_in <= 1'b1;
      end else begin
        ext_irq_in <= 2'h1 << (i % 2);
      end
      wait_resume();
      if (i > 2) begin
        chkb(n >= ((i == 3) ? long_filt : short_filt), 1'b1);
        chkb(n < ((i == 3) ? long_filt : short_filt) + 12, 1'b1);
      end
      chkb(take_isr_out, 1'b0);
      chkb(boot_from_reset_out, 1'b0);
      chkb(flash_power_off_out, 1'b0);
      adc_done_in <= 1'b0;
      ext_irq_in <= 2'h0;
      wr(8'h33, 8'h00);
    end
    $display("test modes done");
  endtask
  task automatic t_sources();
    wr(8'h35, 8'h80);
    wr(8'h33, 8'h03);
    core.exec_sleep(1'b0);
    two_wire_match_in <= 1'b1;
    wait_resume();
    chk(8'(n), 8'h04);
    two_wire_match_in <= 1'b0;
    wr(8'h33, 8'h05);
    core.exec_sleep(1'b0);
    timer2_irq_in <= 1'b1;
    wait_resume();
    chk(8'(n), 8'h04);
    timer2_irq_in <= 1'b0;
    // watchdog wakes s0 only once enabled
    wr(8'h33, 8'h0d);
    core.exec_sleep(1'b0);
    watchdog_irq_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    #1 chkb(sleeping_out, 1'b1);
    watchdog_irq_en_in <= 1'b1;
    wait_resume();
    chkb(n >= short_filt + 4, 1'b1);
    wr(8'h33, 8'h07);
    core.exec_sleep(1'b0);
    two_wire_match_in <= 1'b1;
    timer2_irq_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    #1 chkb(sleeping_out, 1'b1);
    ext_irq_in <= 2'h2;
    wait_resume();
    chkb(boot_from_reset_out, 1'b0);
    ext_irq_in <= 2'h0;
    two_wire_match_in <= 1'b0;
    timer2_irq_in <= 1'b0;
    watchdog_irq_in <= 1'b0;
    watchdog_irq_en_in <= 1'b0;
    // frozen clock enable holds off the wake
    wr(8'h33, 8'h01);
    core.exec_sleep(1'b0);
    clk_en_in <= 1'b0;
    irq_any_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    #1 chkb(resume_out, 1'b0);
    chkb(sleeping_out, 1'b1);
    clk_en_in <= 1'b1;
    wait_resume();
    chk(8'(n), 8'h04);
    irq_any_in <= 1'b0;
    wr(8'h33, 8'h00);
    $display("test sources done");
  endtask
  task automatic t_reset();
    wr(8'h64, 8'h01);
    wr(8'h33, 8'h01);
    core.exec_sleep(1'b0);
    rst_n_in <= 1'b0;
    #1 chkb(sleeping_out, 1'b0);
    chkb(core_clk_en_out, 1'b1);
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    #1 chkb(boot_from_reset_out, 1'b1);
    rc(8'h64, 8'h00);
    chk(module_clk_en0_out, 8'hff);
    $display("test reset done");
  endtask

  initial begin
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    #1 chkb(boot_from_reset_out, 1'b1);
    t_regs();
    t_vector();
    t_idle();
    t_noop();
    t_modes();
    t_sources();
    t_reset();
    wrap_up();
  end
  // hang guard, about 40000 cycles
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
endmodule
